// ---- dhtp_defines.svh ----
`ifndef DHTP_DEFINES_SVH
`define DHTP_DEFINES_SVH

`define DHTP_OFF_CFG     12'h000
`define DHTP_OFF_AMODE   12'h004
`define DHTP_OFF_BMODE   12'h008
`define DHTP_OFF_CTL     12'h00C
`define DHTP_OFF_IMR     12'h018
`define DHTP_OFF_RIS     12'h01C
`define DHTP_OFF_MIS     12'h020
`define DHTP_OFF_ICR     12'h024
`define DHTP_OFF_AILR    12'h028
`define DHTP_OFF_BILR    12'h02C
`define DHTP_OFF_AMATCH  12'h030
`define DHTP_OFF_BMATCH  12'h034
`define DHTP_OFF_APRE    12'h038
`define DHTP_OFF_BPRE    12'h03C
`define DHTP_OFF_APMATCH 12'h040
`define DHTP_OFF_BPMATCH 12'h044
`define DHTP_OFF_ACOUNT  12'h048
`define DHTP_OFF_BCOUNT  12'h04C

`define DHTP_BASE_T0     32'h40030000
`define DHTP_BASE_T1     32'h40031000
`define DHTP_BASE_T2     32'h40032000

`define DHTP_RST16       32'h0000FFFF
`define DHTP_RST32       32'hFFFFFFFF

`define DHTP_CFG_32      3'h0
`define DHTP_CFG_RTC     3'h1
`define DHTP_CFG_SPLIT   3'h4

`define DHTP_MODE_ONE    2'h1
`define DHTP_MODE_PER    2'h2
`define DHTP_MODE_CAP    2'h3

// control register bit positions, first half then second half
`define DHTP_CTL_AEN     0
`define DHTP_CTL_ASTALL  1
`define DHTP_CTL_AEVT    2
`define DHTP_CTL_RTCEN   4
`define DHTP_CTL_AOTE    5
`define DHTP_CTL_AINV    6
`define DHTP_CTL_BEN     8
`define DHTP_CTL_BSTALL  9
`define DHTP_CTL_BEVT    10
`define DHTP_CTL_BOTE    13
`define DHTP_CTL_BINV    14
`define DHTP_CTL_MASK    32'h00007F7F

// interrupt flag positions
`define DHTP_INT_ATO     0
`define DHTP_INT_ACM     1
`define DHTP_INT_ACE     2
`define DHTP_INT_RTC     3
`define DHTP_INT_BTO     8
`define DHTP_INT_BCM     9
`define DHTP_INT_BCE     10
`define DHTP_INT_MASK    32'h0000070F

`endif

// ---- dhtp_pin_model.sv ----
`timescale 1ns/10ps
module dhtp_pin_model (
    input  wire logic        mclk,    // clock
    input  wire logic [1:0]  pwm_in,  // pwm pins, bit 0 first
    output logic [1:0]       ccp_out, // capture pins driven
    output logic [1:0][15:0] hi_len,  // last high run
    output logic [1:0][15:0] lo_len   // last low run
);
    logic [1:0][15:0] run_reg;
    logic [1:0]       last_reg;
    logic [4:0]       div_reg;
    initial begin
        ccp_out = 2'b00;
        hi_len = '0;
        lo_len = '0;
        run_reg = '0;
        last_reg = 2'b00;
        div_reg = 5'h00;
    end
    // slow edges on the capture pins, ignored by halves in pwm mode
    always @(posedge mclk) begin
        div_reg <= div_reg + 5'h01;
        if (div_reg == 5'h1F) ccp_out[0] <= ~ccp_out[0];
        if (div_reg == 5'h0F) ccp_out[1] <= ~ccp_out[1];
        for (int i = 0; i < 2; i++) begin
            last_reg[i] <= pwm_in[i];
            if (pwm_in[i] !== last_reg[i]) begin
                run_reg[i] <= 16'h0001;
                if (last_reg[i]) hi_len[i] <= run_reg[i];
                else lo_len[i] <= run_reg[i];
            end else begin
                run_reg[i] <= run_reg[i] + 16'h0001;
            end
        end
    end
endmodule // dhtp_pin_model

// ---- dhtp_pkg.sv ----
package dhtp_pkg;
    typedef enum logic [1:0] {
        dhtp_idle,
        dhtp_count,
        dhtp_pwm,
        dhtp_capture
    } dhtp_run_e;
    typedef logic [15:0] dhtp_half_t;
endpackage

// ---- dhtp_timer.sv ----
`timescale 1ns/10ps
`include "dhtp_defines.svh"
// What this block does
// - alternate select one, capture bit zero, mode two selects pwm per half
// - a control bit per half inverts that half's pwm output
// - prescale and prescale match are programmed before enabling a half
// - setting a half's enable starts counting and pwm output
// - pwm counting repeats every period until disabled
// - interval load written during pwm changes the next period
// - three instances with bases 0x1000 apart, offsets decoded locally
// - first half load, match, count reset to 16 or 32 bit all ones
// - configuration: 0 timer32, 1 rtc32, 2-3 reserved, 4-7 two halves
// - control has per-half stall and output trigger enables
// - status reads have no side effect; write one to clear flags
// - mode field: 1 one-shot, 2 periodic, 3 capture, 0 reserved; mode 1 reloads at zero and keeps counting like mode 2
// - pwm counts down to zero then reloads start and prescale
// - pwm asserts at start value, deasserts at match, before invert
// - edge field: 00 rising, 01 falling, 10 reserved, 11 both
module dhtp_timer #(
    parameter logic [31:0] BASE_ADDR = `DHTP_BASE_T0
) (
    input  wire logic        mclk,         // system clock
    input  wire logic        rst,          // sync reset, high
    input  wire logic [31:0] paddr,        // apb address
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb enable
    input  wire logic        pwrite,       // apb write
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error
    input  wire logic        ccp_a_in,     // first half capture pin
    input  wire logic        ccp_b_in,     // second half capture pin
    input  wire logic        debug_halt,   // debugger stall request
    output logic             pwm_a_out,    // first half pwm
    output logic             pwm_b_out,    // second half pwm
    output logic             adc_trigger   // converter trigger pulse
);
    logic [2:0]  cfg_reg;
    logic [3:0]  amode_reg, bmode_reg;
    logic [31:0] ctl_reg, imr_reg, ris_reg;
    logic [31:0] ailr_reg, amatch_reg, acnt_reg;
    logic [15:0] bilr_reg, bmatch_reg, bcnt_reg;
    logic [7:0]  apre_reg, bpre_reg, apm_reg, bpm_reg;
    logic [7:0]  apcnt_reg, bpcnt_reg;
    logic        ccp_a_reg, ccp_b_reg;
    logic        pwm_a_reg, pwm_b_reg, trig_reg;
    logic        a_stall, b_stall;
    logic [31:0] rd_next, set_flags;
    logic        wr, rd_ok, split, is32;
    logic        a_en, b_en, a_tick, b_tick;
    logic        a_edge, b_edge, a_to, b_to;
    logic        a_cm, b_cm, a_ce, b_ce, rtc_ev;
    dhtp_pkg::dhtp_run_e a_run, b_run;

    // decodes pwm/capture/timer use of a half
    function automatic dhtp_pkg::dhtp_run_e run_of(input logic [3:0] m,
                                                   input logic en);
        if (!en)
            return dhtp_pkg::dhtp_idle;
        if (m[3] && !m[2] && m[1:0] == `DHTP_MODE_PER)
            return dhtp_pkg::dhtp_pwm;
        if (m[1:0] == `DHTP_MODE_CAP)
            return dhtp_pkg::dhtp_capture;
        if (m[1:0] == 2'h0)
            return dhtp_pkg::dhtp_idle; // reserved mode does nothing
        return dhtp_pkg::dhtp_count;
    endfunction

    // selected edge seen on the pin
    function automatic logic edge_of(input logic [1:0] sel,
                                     input logic now, input logic prev);
        unique case (sel)
            2'h0: return now && !prev;
            2'h1: return !now && prev;
            2'h3: return now != prev;
            default: return 1'b0;
        endcase
    endfunction

    assign wr      = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign split   = cfg_reg[2];
    assign is32    = (cfg_reg == `DHTP_CFG_32) || (cfg_reg == `DHTP_CFG_RTC);
    assign rd_ok   = paddr[31:12] == BASE_ADDR[31:12];
    assign pslverr = psel && penable && !rd_ok;
    // stalling holds a counter while the debugger halts the core
    assign a_en = ctl_reg[`DHTP_CTL_AEN]
               && !(debug_halt && ctl_reg[`DHTP_CTL_ASTALL]);
    assign b_en = ctl_reg[`DHTP_CTL_BEN] && split
               && !(debug_halt && ctl_reg[`DHTP_CTL_BSTALL]);
    // a stalled half keeps its count instead of reloading on resume
    assign a_stall = debug_halt && ctl_reg[`DHTP_CTL_ASTALL]
                  && ctl_reg[`DHTP_CTL_AEN];
    assign b_stall = debug_halt && ctl_reg[`DHTP_CTL_BSTALL]
                  && ctl_reg[`DHTP_CTL_BEN];
    assign a_run = run_of(amode_reg, a_en);
    assign b_run = run_of(bmode_reg, b_en);
    // prescaler only extends the halves in split use
    assign a_tick = !split || apcnt_reg == 8'h00;
    assign b_tick = bpcnt_reg == 8'h00;
    assign a_edge = edge_of(ctl_reg[`DHTP_CTL_AEVT+:2], ccp_a_in, ccp_a_reg);
    assign b_edge = edge_of(ctl_reg[`DHTP_CTL_BEVT+:2], ccp_b_in, ccp_b_reg);
    assign a_to = a_run == dhtp_pkg::dhtp_count && a_tick
               && cfg_reg != `DHTP_CFG_RTC
               && (split ? acnt_reg[15:0] == 16'h0000 : acnt_reg == 32'h0);
    assign b_to = b_run == dhtp_pkg::dhtp_count && b_tick
               && bcnt_reg == 16'h0000;
    assign a_ce = a_run == dhtp_pkg::dhtp_capture && split && a_edge
               && amode_reg[2];
    assign b_ce = b_run == dhtp_pkg::dhtp_capture && b_edge && bmode_reg[2];
    assign a_cm = a_run == dhtp_pkg::dhtp_capture && split && a_edge
               && !amode_reg[2] && acnt_reg[15:0] == amatch_reg[15:0];
    assign b_cm = b_run == dhtp_pkg::dhtp_capture && b_edge
               && !bmode_reg[2] && bcnt_reg == bmatch_reg;
    assign rtc_ev = cfg_reg == `DHTP_CFG_RTC && a_en
                 && ctl_reg[`DHTP_CTL_RTCEN] && acnt_reg == amatch_reg;
    always_comb begin
        set_flags = 32'h0;
        set_flags[`DHTP_INT_ATO] = a_to;
        set_flags[`DHTP_INT_ACM] = a_cm;
        set_flags[`DHTP_INT_ACE] = a_ce;
        set_flags[`DHTP_INT_RTC] = rtc_ev;
        set_flags[`DHTP_INT_BTO] = b_to;
        set_flags[`DHTP_INT_BCM] = b_cm;
        set_flags[`DHTP_INT_BCE] = b_ce;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_reg   <= 3'h0;
            amode_reg <= 4'h0;
            bmode_reg <= 4'h0;
            ctl_reg   <= 32'h0;
            imr_reg   <= 32'h0;
        end else if (wr && rd_ok) begin
            unique case (paddr[11:0])
                `DHTP_OFF_CFG:   cfg_reg   <= pwdata[2:0];
                `DHTP_OFF_AMODE: amode_reg <= pwdata[3:0];
                `DHTP_OFF_BMODE: bmode_reg <= pwdata[3:0];
                `DHTP_OFF_CTL:   ctl_reg   <= pwdata & `DHTP_CTL_MASK;
                `DHTP_OFF_IMR:   imr_reg   <= pwdata & `DHTP_INT_MASK;
                default: ;
            endcase
        end
    end

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge mclk) begin
        if (rst)
            ris_reg <= 32'h0;
        else if (wr && rd_ok && paddr[11:0] == `DHTP_OFF_ICR)
            ris_reg <= (ris_reg & ~pwdata) | set_flags;
        else
            ris_reg <= ris_reg | set_flags;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            apre_reg <= 8'h00;
            bpre_reg <= 8'h00;
            apm_reg  <= 8'h00;
            bpm_reg  <= 8'h00;
            bilr_reg <= 16'hFFFF;
            bmatch_reg <= 16'hFFFF;
        end else if (wr && rd_ok) begin
            unique case (paddr[11:0])
                `DHTP_OFF_APRE:    apre_reg   <= pwdata[7:0];
                `DHTP_OFF_BPRE:    bpre_reg   <= pwdata[7:0];
                `DHTP_OFF_APMATCH: apm_reg    <= pwdata[7:0];
                `DHTP_OFF_BPMATCH: bpm_reg    <= pwdata[7:0];
                `DHTP_OFF_BILR:    bilr_reg   <= pwdata[15:0];
                `DHTP_OFF_BMATCH:  bmatch_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // reset value follows the width selected; cfg is 0 at reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            ailr_reg   <= `DHTP_RST32;
            amatch_reg <= `DHTP_RST32;
        end else if (wr && rd_ok && paddr[11:0] == `DHTP_OFF_CFG) begin
            ailr_reg   <= pwdata[2] ? `DHTP_RST16 : `DHTP_RST32;
            amatch_reg <= pwdata[2] ? `DHTP_RST16 : `DHTP_RST32;
        end else if (wr && rd_ok && paddr[11:0] == `DHTP_OFF_AILR) begin
            ailr_reg   <= split ? {16'h0, pwdata[15:0]} : pwdata;
        end else if (wr && rd_ok && paddr[11:0] == `DHTP_OFF_AMATCH) begin
            amatch_reg <= split ? {16'h0, pwdata[15:0]} : pwdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ccp_a_reg <= 1'b0;
            ccp_b_reg <= 1'b0;
        end else begin
            ccp_a_reg <= ccp_a_in;
            ccp_b_reg <= ccp_b_in;
        end
    end

    // first half: 32-bit timer, rtc up-counter, or 16-bit half
    always_ff @(posedge mclk) begin
        if (rst) begin
            acnt_reg  <= `DHTP_RST32;
            apcnt_reg <= 8'h00;
        end else if (a_stall) begin
            acnt_reg  <= acnt_reg; // frozen while halted
            apcnt_reg <= apcnt_reg;
        end else if (a_run == dhtp_pkg::dhtp_idle) begin
            acnt_reg  <= ailr_reg; // load armed while disabled
            apcnt_reg <= apre_reg;
            if (cfg_reg == `DHTP_CFG_RTC)
                acnt_reg <= 32'h0;
        end else if (cfg_reg == `DHTP_CFG_RTC) begin
            if (ctl_reg[`DHTP_CTL_RTCEN])
                acnt_reg <= rtc_ev ? 32'h0 : acnt_reg + 32'h1;
        end else if (a_run == dhtp_pkg::dhtp_capture) begin
            if (amode_reg[2] && a_edge)
                acnt_reg <= acnt_reg; // edge time held for reading
            else if (!amode_reg[2] && a_edge && !a_cm)
                acnt_reg <= acnt_reg - 32'h1;
        end else if (a_tick) begin
            apcnt_reg <= apre_reg;
            if (is32 ? acnt_reg == 32'h0 : acnt_reg[15:0] == 16'h0)
                acnt_reg <= ailr_reg;
            else
                acnt_reg <= acnt_reg - 32'h1;
        end else begin
            apcnt_reg <= apcnt_reg - 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bcnt_reg  <= 16'hFFFF;
            bpcnt_reg <= 8'h00;
        end else if (b_stall) begin
            bcnt_reg  <= bcnt_reg; // frozen while halted
            bpcnt_reg <= bpcnt_reg;
        end else if (b_run == dhtp_pkg::dhtp_idle) begin
            bcnt_reg  <= bilr_reg;
            bpcnt_reg <= bpre_reg;
        end else if (b_run == dhtp_pkg::dhtp_capture) begin
            if (!bmode_reg[2] && b_edge && !b_cm)
                bcnt_reg <= bcnt_reg - 16'h1;
        end else if (b_tick) begin
            bpcnt_reg <= bpre_reg;
            bcnt_reg  <= bcnt_reg == 16'h0 ? bilr_reg
                                            : bcnt_reg - 16'h1;
        end else begin
            bpcnt_reg <= bpcnt_reg - 8'h01;
        end
    end

    // raw pwm level; prescaler match ignored, only the 16-bit count compared
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwm_a_reg <= 1'b0;
            pwm_b_reg <= 1'b0;
        end else begin
            if (a_run != dhtp_pkg::dhtp_pwm || !split)
                pwm_a_reg <= 1'b0;
            else if (acnt_reg[15:0] == ailr_reg[15:0])
                pwm_a_reg <= 1'b1;
            else if (acnt_reg[15:0] == amatch_reg[15:0])
                pwm_a_reg <= 1'b0;
            if (b_run != dhtp_pkg::dhtp_pwm)
                pwm_b_reg <= 1'b0;
            else if (bcnt_reg == bilr_reg)
                pwm_b_reg <= 1'b1;
            else if (bcnt_reg == bmatch_reg)
                pwm_b_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pwm_a_out   <= 1'b0;
            pwm_b_out   <= 1'b0;
            trig_reg    <= 1'b0;
        end else begin
            pwm_a_out <= pwm_a_reg ^ ctl_reg[`DHTP_CTL_AINV];
            pwm_b_out <= pwm_b_reg ^ ctl_reg[`DHTP_CTL_BINV];
            trig_reg  <= (a_to && ctl_reg[`DHTP_CTL_AOTE])
                      || (b_to && ctl_reg[`DHTP_CTL_BOTE]);
        end
    end
    assign adc_trigger = trig_reg;

    always_comb begin
        rd_next = 32'h0;
        unique case (paddr[11:0])
            `DHTP_OFF_CFG:     rd_next = {29'h0, cfg_reg};
            `DHTP_OFF_AMODE:   rd_next = {28'h0, amode_reg};
            `DHTP_OFF_BMODE:   rd_next = {28'h0, bmode_reg};
            `DHTP_OFF_CTL:     rd_next = ctl_reg;
            `DHTP_OFF_IMR:     rd_next = imr_reg;
            `DHTP_OFF_RIS:     rd_next = ris_reg;
            `DHTP_OFF_MIS:     rd_next = ris_reg & imr_reg;
            `DHTP_OFF_AILR:    rd_next = ailr_reg;
            `DHTP_OFF_BILR:    rd_next = {16'h0, bilr_reg};
            `DHTP_OFF_AMATCH:  rd_next = amatch_reg;
            `DHTP_OFF_BMATCH:  rd_next = {16'h0, bmatch_reg};
            `DHTP_OFF_APRE:    rd_next = {24'h0, apre_reg};
            `DHTP_OFF_BPRE:    rd_next = {24'h0, bpre_reg};
            `DHTP_OFF_APMATCH: rd_next = {24'h0, apm_reg};
            `DHTP_OFF_BPMATCH: rd_next = {24'h0, bpm_reg};
            `DHTP_OFF_ACOUNT:  rd_next = acnt_reg;
            `DHTP_OFF_BCOUNT:  rd_next = {16'h0, bcnt_reg};
            default:           rd_next = 32'h0;
        endcase
    end

    // read data registered in setup, valid in the zero-wait access
    always_ff @(posedge mclk) begin
        if (rst)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= rd_ok ? rd_next : 32'h0;
    end
endmodule // dhtp_timer

// ---- dhtp_timer_assertions.sv ----
`timescale 1ns/10ps
`include "dhtp_defines.svh"
module dhtp_timer_chk #(
    parameter logic [31:0] BASE_ADDR = `DHTP_BASE_T0
) (
    input wire logic        mclk,        // clock
    input wire logic        rst,         // sync reset
    input wire logic [31:0] paddr,       // apb address
    input wire logic        psel,        // apb select
    input wire logic        penable,     // apb enable
    input wire logic        pwrite,      // apb write
    input wire logic [31:0] pwdata,      // apb write data
    input wire logic [31:0] prdata,      // apb read data
    input wire logic        pready,      // apb ready
    input wire logic        pslverr,     // apb error
    input wire logic        pwm_a_out,   // first pwm pin
    input wire logic        pwm_b_out,   // second pwm pin
    input wire logic        adc_trigger  // converter trigger
);
    logic        acc;
    logic        in_pg;
    logic        rd_ok;
    logic        wr_ctl;
    logic [11:0] off;
    assign acc = psel && penable;
    assign in_pg = (paddr[31:12] == BASE_ADDR[31:12]);
    assign off = paddr[11:0];
    assign rd_ok = acc && !pwrite && in_pg;
    assign wr_ctl = acc && pwrite && in_pg && off == `DHTP_OFF_CTL;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_ready_high: assert property (acc |-> pready)
        else $error("ready low in access phase");
    chk_page_error: assert property (acc && !in_pg |->
        pslverr && (pwrite || prdata == 32'h0))
        else $error("foreign page not refused");
    chk_page_ok: assert property (acc && in_pg |-> !pslverr)
        else $error("error raised inside own page");
    chk_unmapped_zero: assert property (rd_ok && off > 12'h04C |->
        prdata == 32'h0) else $error("unmapped read not zero");
    chk_cfg_width: assert property (rd_ok && off == `DHTP_OFF_CFG |->
        prdata[31:3] == 29'h0) else $error("config upper bits set");
    chk_mode_width: assert property (rd_ok && (off == `DHTP_OFF_AMODE
        || off == `DHTP_OFF_BMODE) |-> prdata[31:4] == 28'h0)
        else $error("mode upper bits set");
    chk_ctl_bits: assert property (rd_ok && off == `DHTP_OFF_CTL |->
        (prdata & ~`DHTP_CTL_MASK) == 32'h0)
        else $error("control reserved bits set");
    chk_flag_bits: assert property (rd_ok && (off == `DHTP_OFF_RIS
        || off == `DHTP_OFF_MIS) |-> (prdata & ~`DHTP_INT_MASK) == 32'h0)
        else $error("status reserved bits set");
    chk_a_off: assert property (wr_ctl && !pwdata[0] && !pwdata[6]
        |-> ##4 (!pwm_a_out) [*2]) else $error("first pwm not low");
    chk_a_inv_idle: assert property (wr_ctl && !pwdata[0] && pwdata[6]
        |-> ##4 pwm_a_out [*2]) else $error("first pwm not inverted");
    chk_b_off: assert property (wr_ctl && !pwdata[8] && !pwdata[14]
        |-> ##4 (!pwm_b_out) [*2]) else $error("second pwm not low");
    chk_reset_quiet: assert property ($fell(rst) |->
        !pwm_a_out && !pwm_b_out && !adc_trigger)
        else $error("outputs active after reset");
    cover property (acc && !in_pg);
    cover property ($rose(pwm_a_out));
    cover property ($rose(pwm_b_out));
    cover property (wr_ctl && pwdata[6]);
    cover property (adc_trigger);
endmodule // dhtp_timer_chk
bind dhtp_timer dhtp_timer_chk #(.BASE_ADDR(BASE_ADDR)) dhtp_timer_chk_inst (
    .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_a_out(pwm_a_out), .pwm_b_out(pwm_b_out),
    .adc_trigger(adc_trigger));

// ---- dhtp_timer_tb_top.sv ----
`timescale 1ns/10ps
`include "dhtp_defines.svh"
module dhtp_timer_tb_top;
    localparam logic [31:0] BASE = `DHTP_BASE_T1;
    logic             mclk;
    logic             rst;
    logic [31:0]      paddr;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             debug_halt;
    logic             trig;
    logic [1:0]       pwm;
    logic [1:0]       ccp;
    logic [1:0][15:0] hi_len;
    logic [1:0][15:0] lo_len;
    logic [32:0]      exp_q[$];
    int               bad_count;
    int               num_checks;
    int               seed;

    dhtp_timer #(.BASE_ADDR(BASE)) dhtp_timer_inst (
        .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ccp_a_in(ccp[0]), .ccp_b_in(ccp[1]), .debug_halt(debug_halt),
        .pwm_a_out(pwm[0]), .pwm_b_out(pwm[1]), .adc_trigger(trig));
    dhtp_pin_model dhtp_pin_model_inst (
        .mclk(mclk), .pwm_in(pwm), .ccp_out(ccp), .hi_len(hi_len),
        .lo_len(lo_len));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check_bus(input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected read at %h exp %h got %h", paddr, e, g);
        end
    endtask

    task automatic check_len(input string n, input logic [15:0] e,
                             input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s exp %0d got %0d", n, e, g);
        end
    endtask

    // request held until pready is seen high, then one idle cycle
    task automatic apb(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [11:0] o, input logic [31:0] d);
        apb(BASE + {20'h0, o}, 1'b1, d);
    endtask

    task automatic rd(input logic [11:0] o, input logic [32:0] e);
        exp_q.push_back(e);
        apb(BASE + {20'h0, o}, 1'b0, 32'h0);
    endtask

    task automatic pwm_chk(input int h, input int hi, input int lo);
        repeat (3 * (hi + lo) + 12) @(posedge mclk);
        check_len("pwm high run", hi[15:0], hi_len[h]);
        check_len("pwm low run", lo[15:0], lo_len[h]);
    endtask

    // trigger pulses seen over 40 settled samples
    task automatic trig_chk(input int e);
        int n;
        n = 0;
        @(posedge mclk);
        repeat (40) begin
            @(negedge mclk);
            if (trig === 1'b1)
                n++;
        end
        @(posedge mclk);
        check_len("trigger pulses", e[15:0], n[15:0]);
    endtask

    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("unexpected read exp none got %h", prdata);
            end else begin
                check_bus(exp_q.pop_front(), {pslverr, prdata});
            end
        end
    end

    initial begin
        int l;
        int m;
        seed = 32'h286b891e;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        debug_halt = 1'b0;
        bad_count = 0;
        num_checks = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(`DHTP_OFF_CFG, 33'h0);
        rd(`DHTP_OFF_AILR, {1'b0, `DHTP_RST32});
        rd(`DHTP_OFF_AMATCH, {1'b0, `DHTP_RST32});
        rd(`DHTP_OFF_ACOUNT, {1'b0, `DHTP_RST32});
        rd(`DHTP_OFF_BILR, {1'b0, `DHTP_RST16});
        rd(`DHTP_OFF_CTL, 33'h0);
        wr(`DHTP_OFF_CFG, 32'hFFFFFFFF);
        rd(`DHTP_OFF_CFG, 33'h7);
        wr(`DHTP_OFF_CFG, {29'h0, `DHTP_CFG_SPLIT});
        rd(`DHTP_OFF_AILR, {1'b0, `DHTP_RST16});
        wr(`DHTP_OFF_AMODE, 32'hFFFFFFFF);
        rd(`DHTP_OFF_AMODE, 33'hF);
        rd(12'h050, 33'h0);
        exp_q.push_back({1'b1, 32'h0});
        apb(`DHTP_BASE_T0 + 32'h4, 1'b0, 32'h0);
        wr(`DHTP_OFF_IMR, 32'hFFFFFFFF);
        rd(`DHTP_OFF_IMR, {1'b0, `DHTP_INT_MASK});
        wr(`DHTP_OFF_ICR, 32'hFFFFFFFF);
        rd(`DHTP_OFF_RIS, 33'h0);
        rd(`DHTP_OFF_MIS, 33'h0);
        wr(`DHTP_OFF_AMODE, 32'hA);
        wr(`DHTP_OFF_AILR, 32'h4);
        wr(`DHTP_OFF_AMATCH, 32'h2);
        wr(`DHTP_OFF_CTL, 32'h1);
        pwm_chk(0, 2, 3);
        wr(`DHTP_OFF_AILR, 32'h7);
        pwm_chk(0, 5, 3);
        wr(`DHTP_OFF_CTL, 32'h40);
        wr(`DHTP_OFF_AMATCH, 32'h1);
        wr(`DHTP_OFF_APRE, 32'h1);
        wr(`DHTP_OFF_APMATCH, 32'h5);
        rd(`DHTP_OFF_APMATCH, 33'h5);
        wr(`DHTP_OFF_CTL, 32'h41);
        pwm_chk(0, 4, 12);
        for (int i = 0; i < 3; i++) begin
            l = 4 + ($random(seed) & 7);
            m = 1 + (($random(seed) & 32'hFF) % (l - 1));
            wr(`DHTP_OFF_CTL, 32'h0);
            wr(`DHTP_OFF_BMODE, 32'hA);
            wr(`DHTP_OFF_BILR, 32'(l));
            wr(`DHTP_OFF_BMATCH, 32'(m));
            wr(`DHTP_OFF_CTL, 32'h100);
            pwm_chk(1, l - m, m + 1);
        end
        wr(`DHTP_OFF_CTL, 32'h0);
        wr(`DHTP_OFF_AMODE, 32'h2);
        wr(`DHTP_OFF_AILR, 32'h3);
        wr(`DHTP_OFF_APRE, 32'h0);
        wr(`DHTP_OFF_CTL, 32'h23);
        trig_chk(10);
        rd(`DHTP_OFF_RIS, 33'h1);
        rd(`DHTP_OFF_MIS, 33'h1);
        debug_halt <= 1'b1;
        trig_chk(0);
        debug_halt <= 1'b0;
        trig_chk(10);
        wr(`DHTP_OFF_CTL, 32'h0);
        wr(`DHTP_OFF_ICR, 32'h1);
        rd(`DHTP_OFF_RIS, 33'h0);
        wr(`DHTP_OFF_AMODE, 32'h3);
        wr(`DHTP_OFF_AILR, 32'h8);
        wr(`DHTP_OFF_AMATCH, 32'h6);
        wr(`DHTP_OFF_CTL, 32'h1);
        repeat (256) @(posedge mclk);
        rd(`DHTP_OFF_ACOUNT, 33'h6);
        rd(`DHTP_OFF_RIS, 33'h2);
        stop_test();
    end
endmodule // dhtp_timer_tb_top
